// >>> core/cfg_readout.v
// Serial configuration memory read-out with cascade, standby and programming mode
// =====================================================================
// How it works
// - Stored image streamed serially on data output
// - Ready pulled low during power-on reset
// - Clock after last bit: chain low, data off
// - Low select enables this memory's data
// - Active reset level clears the address counter
// - Reset polarity is a stored, programmable setting
// - Low program enable selects programming mode
// - Programming over two-wire bus in that mode
// - Select high puts memory in standby
// - Standby keeps data floating regardless of enable
// - Reset level clears counter and floats data
// - Select high after reset keeps counter halted
// - Reset clears and floats even with select low
// - Counter cleared automatically at power-up
`timescale 1ns/1ps
`include "cfg_readout_defs.vh"
module cfg_readout #(
  parameter ADDR_W = 16,
  parameter [31:0] IMAGE_BITS = `IMAGE_BITS_DEFAULT,
  parameter [31:0] POR_CYCLES = `POR_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // FPGA side pins
  input wire i_fpga_config_clock,
  input wire i_chip_select_n,
  input wire i_reset_oe,
  output reg o_data,
  output reg o_data_oe,
  output reg o_chain_enable_out_n,
  // Power-on reset indicator, open drain
  output reg o_ready_out,
  output reg o_ready_oe,
  // Programming pins
  input wire i_serial_program_enable_n,
  input wire i_prog_scl,
  input wire i_prog_sda,
  output reg o_prog_sda,
  output reg o_prog_sda_oe,
  // Status
  output reg o_standby,
  output reg o_in_system_programming
);
  // =====================================================================
  // Input synchronisers
  wire clk_s;
  wire cs_n_s;
  wire roe_s;
  wire pen_n_s;
  wire scl_s;
  wire sda_s;
  cfg_sync2 #(
    .W(6),
    .INIT({`IDLE_CFG_CLOCK, `IDLE_SELECT_N, `IDLE_RESET_OE,
           `IDLE_PROG_EN_N, `IDLE_PROG_SCL, `IDLE_PROG_SDA})
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async({i_fpga_config_clock, i_chip_select_n, i_reset_oe,
              i_serial_program_enable_n, i_prog_scl, i_prog_sda}),
    .o_sync({clk_s, cs_n_s, roe_s, pen_n_s, scl_s, sda_s})
  );
  // =====================================================================
  // Memory and stored settings
  reg mem [0:IMAGE_BITS-1];
  reg rst_pol_reg;
  reg clk_d_reg;
  reg scl_d_reg;
  reg sda_d_reg;
  reg [31:0] por_cnt_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [1:0] state_reg;
  wire clk_rise;
  wire scl_rise;
  wire prog_start;
  wire prog_stop;
  wire in_prog;
  wire por_busy;
  wire cnt_reset;
  assign clk_rise = clk_s & ~clk_d_reg;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign prog_start = scl_s & sda_d_reg & ~sda_s;
  assign prog_stop = scl_s & ~sda_d_reg & sda_s;
  assign in_prog = ~pen_n_s;
  assign por_busy = (por_cnt_reg != 32'h0);
  // Polarity selects which level of the pin means reset
  assign cnt_reset = (roe_s == rst_pol_reg);
  function last_addr;
    input [ADDR_W-1:0] a;
    begin
      last_addr = ({{(32-ADDR_W){1'b0}}, a} == IMAGE_BITS - 32'h1);
    end
  endfunction
  function [ADDR_W-1:0] addr_inc;
    input [ADDR_W-1:0] a;
    begin
      addr_inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction
  // =====================================================================
  // Pin edge detection, idle levels after reset
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clk_d_reg <= `IDLE_CFG_CLOCK;
      scl_d_reg <= `IDLE_PROG_SCL;
      sda_d_reg <= `IDLE_PROG_SDA;
    end else begin
      clk_d_reg <= clk_s;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  // =====================================================================
  // Two-wire programming receiver: addr bits then data bit, or polarity
  reg [ADDR_W+1:0] sh_reg;
  reg [7:0] bits_reg;
  reg prog_act_reg;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_reg <= {(ADDR_W+2){1'b0}};
      bits_reg <= 8'h0;
      prog_act_reg <= 1'b0;
      rst_pol_reg <= `RST_POL_ACTIVE_LOW;
      o_prog_sda <= 1'b0;
      o_prog_sda_oe <= 1'b0;
    end else begin
      o_prog_sda <= 1'b0;
      o_prog_sda_oe <= 1'b0;
      if (!in_prog) begin
        prog_act_reg <= 1'b0;
        bits_reg <= 8'h0;
      end else if (prog_start) begin
        prog_act_reg <= 1'b1;
        bits_reg <= 8'h0;
      end else if (prog_stop) begin
        prog_act_reg <= 1'b0;
      end else if (prog_act_reg && scl_rise) begin
        sh_reg <= {sh_reg[ADDR_W:0], sda_s};
        bits_reg <= bits_reg + 8'h1;
        if ({24'h0, bits_reg} == ADDR_W + 1) begin
          if (sh_reg[ADDR_W] == `PROG_CMD_WRITE)
            mem[sh_reg[ADDR_W-1:0]] <= sda_s;
          else
            rst_pol_reg <= sda_s;
          bits_reg <= 8'h0;
          o_prog_sda_oe <= 1'b1;
        end
      end
    end
  end
  // =====================================================================
  // Power-on reset indicator
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      por_cnt_reg <= POR_CYCLES;
      o_ready_out <= 1'b0;
      o_ready_oe <= 1'b1;
    end else begin
      o_ready_out <= 1'b0;
      if (por_busy)
        por_cnt_reg <= por_cnt_reg - 32'h1;
      o_ready_oe <= por_busy;
    end
  end
  // =====================================================================
  // Status outputs
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_standby <= 1'b0;
      o_in_system_programming <= 1'b0;
    end else begin
      o_in_system_programming <= in_prog;
      o_standby <= cs_n_s;
    end
  end
  // =====================================================================
  // Address counter and data output
  localparam [1:0] ST_SEND = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_reg <= {ADDR_W{1'b0}};
      state_reg <= ST_SEND;
      o_data <= 1'b0;
      o_data_oe <= 1'b0;
      o_chain_enable_out_n <= 1'b1;
    end else if (por_busy || in_prog || cnt_reset) begin
      addr_reg <= {ADDR_W{1'b0}};
      state_reg <= ST_SEND;
      o_chain_enable_out_n <= 1'b1;
      o_data_oe <= 1'b0;
    end else if (cs_n_s) begin
      o_data_oe <= 1'b0;
    end else begin
      case (state_reg)
        ST_SEND: begin
          o_data_oe <= 1'b1;
          o_data <= mem[addr_reg];
          if (clk_rise) begin
            if (last_addr(addr_reg)) begin
              state_reg <= ST_DONE;
              o_chain_enable_out_n <= 1'b0;
              o_data_oe <= 1'b0;
            end else begin
              addr_reg <= addr_inc(addr_reg);
              o_data <= mem[addr_inc(addr_reg)];
            end
          end
        end
        ST_DONE: begin
          o_data_oe <= 1'b0;
          o_chain_enable_out_n <= 1'b0;
        end
        default: begin
          state_reg <= ST_SEND;
          o_data_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> core/cfg_readout_defs.vh
// Constants for the serial configuration memory read-out block
`ifndef CFG_READOUT_DEFS_VH
`define CFG_READOUT_DEFS_VH
// Default image size in bits
`define IMAGE_BITS_DEFAULT 32'd65536
// Power-on reset hold time in cycles
`define POR_CYCLES_DEFAULT 32'd16
// Reset polarity codes
`define RST_POL_ACTIVE_LOW 1'b0
`define RST_POL_ACTIVE_HIGH 1'b1
// Two-wire programming command bits
`define PROG_CMD_WRITE 1'b0
`define PROG_CMD_READ 1'b1
// Idle levels of the synchronised pins
`define IDLE_CFG_CLOCK 1'b0
`define IDLE_SELECT_N 1'b1
`define IDLE_RESET_OE 1'b1
`define IDLE_PROG_EN_N 1'b1
`define IDLE_PROG_SCL 1'b1
`define IDLE_PROG_SDA 1'b1
`endif

// >>> core/cfg_sync2.v
// Two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cfg_sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule

// >>> dv/cfg_readout_properties.sv
// Port assertions for the read-out block
`timescale 1ns/1ps
module cfg_readout_properties #(parameter [31:0] POR_CYCLES = 32'd16) (
  // Clock, reset and inputs
  input wire i_core_clk, input wire i_resetn, input wire i_chip_select_n,
  input wire i_reset_oe, input wire i_serial_program_enable_n,
  // Outputs
  input wire o_data_oe, input wire o_chain_enable_out_n, input wire o_ready_out,
  input wire o_ready_oe, input wire o_prog_sda, input wire o_prog_sda_oe,
  input wire o_standby, input wire o_in_system_programming
);
  // ====
  // Cycles since reset release
  reg [7:0] since_rst_reg;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn)
      since_rst_reg <= 8'h00;
    else if (since_rst_reg != 8'hff)
      since_rst_reg <= since_rst_reg + 8'h01;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  AST_POR_HOLD: assert property (
    since_rst_reg + 8'h01 < POR_CYCLES |-> o_ready_oe && !o_ready_out)
    else $error("ready released early");
  AST_POR_DONE: assert property (since_rst_reg > POR_CYCLES + 2 |-> !o_ready_oe)
    else $error("ready held too long");
  AST_STANDBY_FLOAT: assert property (o_standby |-> !o_data_oe)
    else $error("data driven in standby");
  AST_STANDBY_ENTRY: assert property (
    i_chip_select_n [*6] |-> o_standby && !o_data_oe)
    else $error("no standby with select high");
  AST_RESET_FLOAT: assert property (
    !i_reset_oe [*6] |-> !o_data_oe && o_chain_enable_out_n)
    else $error("reset level did not float data");
  AST_CHAIN_FLOAT: assert property (!o_chain_enable_out_n |-> !o_data_oe)
    else $error("data driven after last bit");
  AST_CHAIN_HOLD: assert property ($rose(o_chain_enable_out_n) |->
    !$past(i_reset_oe, 2) || !$past(i_reset_oe, 3) || !$past(i_reset_oe, 4))
    else $error("chain released without reset");
  AST_PROG_MODE: assert property (
    !i_serial_program_enable_n [*6] |-> o_in_system_programming)
    else $error("programming mode not entered");
  AST_PROG_ACK: assert property (
    o_prog_sda_oe |-> !o_prog_sda && o_in_system_programming)
    else $error("bad acknowledge");
  cover property ($fell(o_chain_enable_out_n));
  cover property (o_prog_sda_oe);
  cover property ($rose(o_standby));
endmodule
bind cfg_readout cfg_readout_properties #(.POR_CYCLES(POR_CYCLES)) i_props (.i_core_clk,
  .i_resetn, .i_chip_select_n, .i_reset_oe, .i_serial_program_enable_n, .o_data_oe,
  .o_chain_enable_out_n, .o_ready_out, .o_ready_oe, .o_prog_sda, .o_prog_sda_oe,
  .o_standby, .o_in_system_programming);

// >>> dv/fpga_master_model.sv
// Master FPGA stand-in supplying the configuration clock
`timescale 1ns/1ps
module fpga_master_model (
  input wire i_core_clk,
  input wire i_go,
  input wire i_slow,
  output reg o_fpga_config_clock
);
  // ====
  // One clock pulse per request, idle low
  initial o_fpga_config_clock = 1'b0;
  always @(negedge i_core_clk)
    if (i_go) begin
      o_fpga_config_clock <= 1'b1;
      repeat (i_slow ? 8 : 4) @(negedge i_core_clk);
      o_fpga_config_clock <= 1'b0;
      repeat (i_slow ? 8 : 4) @(negedge i_core_clk);
    end
endmodule

// >>> dv/cfg_readout_test.sv
// Self-checking bench for the read-out block
`timescale 1ns/1ps
`include "cfg_readout_defs.vh"
module cfg_readout_test;
  reg clk, rstn, cs_n, roe, prg_n, scl, sda, go, slow;
  reg [7:0] img;
  reg [3:0] q[$];
  integer err_total = 0, n_checks = 0, acks = 0, i, b;
  wire dat, oe, chain_n, rdy, rdy_oe, psda, psda_oe, stby, prog_mode, fpga_cfg_clk;
  event look;
  cfg_readout #(.ADDR_W(3), .IMAGE_BITS(32'd8), .POR_CYCLES(32'd4)) i_dut (
    .i_core_clk(clk), .i_resetn(rstn), .i_fpga_config_clock(fpga_cfg_clk),
    .i_chip_select_n(cs_n), .i_reset_oe(roe), .o_data(dat), .o_data_oe(oe),
    .o_chain_enable_out_n(chain_n), .o_ready_out(rdy), .o_ready_oe(rdy_oe),
    .i_serial_program_enable_n(prg_n), .i_prog_scl(scl),
    .i_prog_sda(sda & !(psda_oe & !psda)), .o_prog_sda(psda),
    .o_prog_sda_oe(psda_oe), .o_standby(stby), .o_in_system_programming(prog_mode));
  fpga_master_model i_fpga (.i_core_clk(clk), .i_go(go), .i_slow(slow),
    .o_fpga_config_clock(fpga_cfg_clk));
  // ====
  // Tasks
  task w(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input [3:0] g, input [3:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task note(input [3:0] e);
    q.push_back(e);
    -> look;
  endtask
  task bit_out(input v);
    sda = v;
    w(3);
    scl = 1;
    w(3);
    scl = 0;
    w(3);
  endtask
  task frame(input [4:0] f);
    sda = 1;
    w(3);
    scl = 1;
    w(3);
    sda = 0;
    w(3);
    scl = 0;
    w(3);
    for (b = 4; b >= 0; b = b - 1) bit_out(f[b]);
  endtask
  task pulse;
    slow <= 1'($urandom);
    go <= 1;
    w(1);
    go <= 0;
    w(24);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ====
  // Clock, watchdog, monitor
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000 err_total = err_total + 1;
    tally_and_finish;
  end
  always @(posedge clk) if (psda_oe) acks = acks + 1;
  always @(look) begin
    #1 chk({oe, oe & dat, chain_n, stby}, q.pop_front());
  end
  // ====
  // Main sequence
  initial begin
    rstn = 0;
    cs_n = 1;
    roe = 1;
    prg_n = 1;
    scl = 1;
    sda = 1;
    go = 0;
    slow = 0;
    void'($urandom(32'hc360b595));
    img = 8'($urandom);
    w(5);
    rstn = 1;
    for (i = 0; i < 40 && rdy_oe !== 1'b0; i = i + 1) w(1);
    if (rdy_oe !== 1'b0) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
    chk({2'h0, rdy, rdy_oe}, 4'h0);
    prg_n = 0;
    for (i = 0; i < 8; i = i + 1) frame({`PROG_CMD_WRITE, i[2:0], img[i]});
    w(10);
    chk(acks[3:0], 4'h8);
    chk({3'h0, prog_mode}, 4'h1);
    prg_n = 1;
    w(5);
    cs_n = 0;
    w(6);
    note({1'b1, img[0], 2'b10});
    for (i = 1; i < 8; i = i + 1) begin
      pulse;
      note({1'b1, img[i], 2'b10});
    end
    pulse;
    note(4'h0);
    pulse;
    note(4'h0);
    cs_n = 1;
    w(8);
    note(4'h1);
    roe = 0;
    w(8);
    note(4'h3);
    roe = 1;
    w(4);
    cs_n = 0;
    w(6);
    note({1'b1, img[0], 2'b10});
    pulse;
    note({1'b1, img[1], 2'b10});
    roe = 0;
    w(8);
    note(4'h2);
    roe = 1;
    w(6);
    note({1'b1, img[0], 2'b10});
    w(5);
    tally_and_finish;
  end
endmodule
